// ==== verilog/nfhp_pkg.sv ====
package nfhp_pkg;
	localparam int CLK_MHZ = 40;
	localparam int WE_LOW_NS = 25;
	localparam int WE_HIGH_NS = 25;
	localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int WE_HIGH_CYC = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int RD_LOW_NS = 25;
	localparam int RD_LOW_CYC = (RD_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int ADDR_CYCLES = 5;
	localparam int COL_BITS = 12;
	localparam int ROW_BITS = 17;
	localparam int PAGE_BITS = 6;
	localparam int BLOCK_BITS = 11;
	localparam int PAGE_BYTES = 2112;
	localparam int MAIN_BYTES = 2048;
	localparam int SPARE_BYTES = 64;
	localparam int PAGES_PER_BLOCK = 64;
	localparam int BLOCKS_PER_PLANE = 1024;
	localparam int BLOCKS_TOTAL = 2048;
	localparam int SEGMENT_BYTES = 528;
	localparam logic [3:0] COL_HI_MASK = 4'hf;
	localparam logic [0:0] ROW_TOP_MASK = 1'h1;

	typedef enum logic [1:0] {
		NFHP_OP_CMD,
		NFHP_OP_ADDR,
		NFHP_OP_WRITE,
		NFHP_OP_READ
	} nfhp_op_t;

	typedef struct packed {
		nfhp_op_t op;
		logic [7:0] data;
		logic [COL_BITS-1:0] col;
		logic [ROW_BITS-1:0] row;
	} nfhp_req_t;

	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic rd_n;
		logic wp_n;
	} nfhp_pins_t;
endpackage

// ==== verilog/nfhp_host.sv ====
// How it works
// R1 - Command bytes go out with command latch high, captured on write rising edge.
// R2 - Address bytes go out with address latch high, captured on write rising edge.
// R3 - Every byte written is held stable across the write strobe rising edge.
// R4 - Chip select driven low for cycles; new ones wait while device busy.
// R5 - Device floats bus when deselected; host drives bus only for writes.
// R6 - Read bytes are taken while read strobe is low.
// R7 - Each read strobe falling edge advances the device column; host counts bytes.
// R8 - Write-protect pin driven from a user level; low blocks program and erase.
// R9 - Ready/busy is open drain; low means busy, sampled as input.
// R10 - A full address is sent as five address-latch write cycles.
// R11 - Column goes low byte first; second byte upper nibble is zero.
// R12 - Row follows low byte first; fifth byte carries only row bit 16.
// R13 - Row bits 6 to 16 form the block number.
// R14 - Row bits 0 to 5 form the page within the block.
// R15 - A page holds 2112 bytes: 2048 main plus 64 spare.
// R16 - Device holds two 2112-byte page registers loaded whole.
// R17 - Program works on pages, erase on blocks.
// R18 - One erase clears a whole 64-page block.
// R19 - Device corrects eight bit errors per 528 bytes internally.
// R20 - Array has 1024 blocks per plane, 2048 blocks in all.
// R21 - Block zero is usable as shipped.
// R22 - Device ignores commands below the supply lockout threshold.
// R23 - Device may keep driving data after short read high time.
// R24 - Data bytes go with both latches low, filling the page register.
// R25 - Host never raises both latch strobes in one write cycle.
module nfhp_host
	import nfhp_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// User request
	input wire logic req_valid,
	output logic req_ready,
	input wire nfhp_req_t req,
	input wire logic wp_level_n,
	// User answer
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic dev_busy,
	output logic [15:0] read_count,
	// Device pins
	output nfhp_pins_t pins,
	input wire logic [7:0] shared_bus_lines_in,
	output logic [7:0] shared_bus_lines_out,
	output logic [7:0] shared_bus_lines_oe,
	input wire logic ready_busy_in
);
	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} nfhp_state_t;

	// Strobe counters are four bits wide, so longer phases cannot be served
	if (WE_LOW_CYC < 1 || WE_HIGH_CYC < 1 || RD_LOW_CYC < 1 || WE_LOW_CYC > 16 ||
		WE_HIGH_CYC > 16 || RD_LOW_CYC > 16 || ADDR_CYCLES != 5) begin : g_bad_timing
		$error("nfhp_host: timing constants unusable");
	end

	nfhp_state_t state_q;
	nfhp_op_t op_q;
	logic [2:0] idx_q;
	logic [3:0] cnt_q;
	logic [7:0] byte_q;
	logic [COL_BITS-1:0] col_q;
	logic [ROW_BITS-1:0] row_q;
	logic last_q;

	// R11 R12 address byte order
	function automatic logic [7:0] addr_byte(input logic [2:0] i,
		input logic [COL_BITS-1:0] c, input logic [ROW_BITS-1:0] r);
		case (i)
			3'h0: addr_byte = c[7:0];
			3'h1: addr_byte = {4'h0, c[11:8] & COL_HI_MASK};
			3'h2: addr_byte = r[7:0];
			3'h3: addr_byte = r[15:8];
			3'h4: addr_byte = {7'h00, r[16] & ROW_TOP_MASK};
			default: addr_byte = 8'h00;
		endcase
	endfunction

	// R9 busy is line low
	assign dev_busy = ~ready_busy_in;
	// R4 wait for ready
	assign req_ready = (state_q == ST_IDLE) && ready_busy_in;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			op_q <= NFHP_OP_CMD;
			idx_q <= 3'h0;
			cnt_q <= 4'h0;
			byte_q <= 8'h00;
			col_q <= '0;
			row_q <= '0;
			last_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (req_valid && req_ready) begin
						op_q <= req.op;
						col_q <= req.col;
						row_q <= req.row;
						idx_q <= 3'h0;
						cnt_q <= 4'h0;
						// R10 five address cycles
						last_q <= (req.op != NFHP_OP_ADDR);
						byte_q <= (req.op == NFHP_OP_ADDR) ?
							addr_byte(3'h0, req.col, req.row) : req.data;
						state_q <= ST_LOW;
					end
				end
				ST_LOW: begin
					if (cnt_q == 4'((op_q == NFHP_OP_READ ? RD_LOW_CYC : WE_LOW_CYC) - 1)) begin
						cnt_q <= 4'h0;
						state_q <= ST_HIGH;
					end else begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
				ST_HIGH: begin
					if (cnt_q == 4'(WE_HIGH_CYC - 1)) begin
						cnt_q <= 4'h0;
						if (last_q) begin
							state_q <= ST_IDLE;
						end else begin
							idx_q <= idx_q + 3'h1;
							byte_q <= addr_byte(idx_q + 3'h1, col_q, row_q);
							last_q <= (idx_q + 3'h1 == 3'(ADDR_CYCLES - 1));
							state_q <= ST_LOW;
						end
					end else begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	logic strobe_low;
	logic go;
	logic low_done;
	logic high_done;
	logic enter_low;
	logic busy_d;
	nfhp_op_t op_d;
	assign strobe_low = (state_q == ST_LOW);
	assign go = (state_q == ST_IDLE) && req_valid && req_ready;
	assign low_done = strobe_low &&
		cnt_q == 4'((op_q == NFHP_OP_READ ? RD_LOW_CYC : WE_LOW_CYC) - 1);
	assign high_done = (state_q == ST_HIGH) && cnt_q == 4'(WE_HIGH_CYC - 1);
	// Pins follow the state being entered, so select and latches go active with the strobe fall and stay past its rise
	assign enter_low = go || (strobe_low && !low_done) || (high_done && !last_q);
	assign busy_d = go || strobe_low || ((state_q == ST_HIGH) && !(high_done && last_q));
	assign op_d = go ? req.op : op_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, rd_n: 1'b1, wp_n: 1'b0};
		end else begin
			// R4 select only for a running transfer
			pins.ce_n <= !busy_d;
			// R1 R25 command latch alone
			pins.cle <= busy_d && op_d == NFHP_OP_CMD;
			// R2 address latch alone
			pins.ale <= busy_d && op_d == NFHP_OP_ADDR;
			// R3 R24 write strobe pulse
			pins.we_n <= !(enter_low && op_d != NFHP_OP_READ);
			// R6 read strobe pulse
			pins.rd_n <= !(enter_low && op_d == NFHP_OP_READ);
			// R8 write protect
			pins.wp_n <= wp_level_n;
		end
	end

	// R5 drive only on writes
	assign shared_bus_lines_out = byte_q;
	assign shared_bus_lines_oe = {8{state_q != ST_IDLE && op_q != NFHP_OP_READ}};

	// R6 R7 read capture and count
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			read_count <= 16'h0000;
		end else begin
			rsp_valid <= 1'b0;
			if (strobe_low && op_q == NFHP_OP_READ && cnt_q == 4'(RD_LOW_CYC - 1)) begin
				rsp_valid <= 1'b1;
				rsp_data <= shared_bus_lines_in;
				read_count <= read_count + 16'h0001;
			end
		end
	end

	AST_NO_DUAL_LATCH: assert property (@(posedge core_clk) disable iff (rst)
		!(pins.cle && pins.ale)) else $error("both latches high"); // R25
	AST_CMD_WITH_CLE: assert property (@(posedge core_clk) disable iff (rst)
		$rose(pins.we_n) && $past(op_q) == NFHP_OP_CMD |-> pins.cle && $past(pins.cle))
		else $error("cmd no cle"); // R1
	AST_ADDR_WITH_ALE: assert property (@(posedge core_clk) disable iff (rst)
		$rose(pins.we_n) && op_q == NFHP_OP_ADDR |-> pins.ale && $past(pins.ale))
		else $error("addr no ale"); // R2
	AST_DATA_STABLE: assert property (@(posedge core_clk) disable iff (rst)
		$rose(pins.we_n) |-> $stable(shared_bus_lines_out)) else $error("data moved"); // R3
	AST_IDLE_BUS_FREE: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_IDLE |-> shared_bus_lines_oe == 8'h00) else $error("bus driven idle"); // R5
	AST_START_READY: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_IDLE && !ready_busy_in |=> pins.ce_n) else $error("select while busy"); // R4
	AST_COL_HI_ZERO: assert property (@(posedge core_clk) disable iff (rst)
		op_q == NFHP_OP_ADDR && state_q == ST_LOW && idx_q == 3'h1 |->
		byte_q[7:4] == 4'h0) else $error("col hi nibble"); // R11
	AST_ROW_TOP_ONLY: assert property (@(posedge core_clk) disable iff (rst)
		op_q == NFHP_OP_ADDR && state_q == ST_LOW && idx_q == 3'h4 |->
		byte_q[7:1] == 7'h00) else $error("row top byte"); // R12
	AST_FIVE_ADDR: assert property (@(posedge core_clk) disable iff (rst)
		state_q != ST_IDLE && op_q == NFHP_OP_ADDR |-> idx_q < 3'h5) else $error("addr count"); // R10
	AST_READ_COUNT: assert property (@(posedge core_clk) disable iff (rst)
		rsp_valid |-> read_count == $past(read_count) + 16'h0001) else $error("count"); // R7
	AST_WP_FOLLOW: assert property (@(posedge core_clk) disable iff (rst)
		##1 pins.wp_n == $past(wp_level_n)) else $error("wp"); // R8

	COV_CMD: cover property (@(posedge core_clk) disable iff (rst)
		req_valid && req_ready && req.op == NFHP_OP_CMD);
	COV_ADDR_DONE: cover property (@(posedge core_clk) disable iff (rst)
		op_q == NFHP_OP_ADDR && idx_q == 3'h4 && state_q == ST_HIGH);
	COV_READ: cover property (@(posedge core_clk) disable iff (rst) rsp_valid);
	COV_BUSY_WAIT: cover property (@(posedge core_clk) disable iff (rst)
		req_valid && !ready_busy_in);
endmodule

// ==== tb/nfhp_dev_model.sv ====
module nfhp_dev_model import nfhp_pkg::*; (
	// Device pins
	input wire nfhp_pins_t pins,
	input wire logic [7:0] bus_in,
	output logic [7:0] dev_bus,
	output logic rb_pull,
	// Bench control
	input wire logic busy_req
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cmd_q;
	logic [7:0] addr_q [5];
	logic [COL_BITS-1:0] col_q;
	logic [ROW_BITS-1:0] row_q;
	logic [BLOCK_BITS-1:0] block_num;
	logic [PAGE_BITS-1:0] page_num;
	logic [7:0] out_q = 8'h00;
	int n_q = 0;
	logic [7:0] page_q [PAGE_BYTES];
	assign rb_pull = busy_req;
	assign block_num = row_q[ROW_BITS-1:PAGE_BITS];
	assign page_num = row_q[PAGE_BITS-1:0];
	// capture on write rise, ignored while busy
	always @(posedge pins.we_n) begin
		if (!pins.ce_n && !busy_req && pins.cle) begin
			cmd_q = bus_in;
			n_q = 0;
		end else if (!pins.ce_n && !busy_req && pins.ale && n_q < ADDR_CYCLES) begin
			addr_q[n_q] = bus_in;
			n_q++;
			col_q = {addr_q[1][3:0], addr_q[0]};
			row_q = {addr_q[4][0], addr_q[3], addr_q[2]};
		end else if (!pins.ce_n && !busy_req) begin
			page_q[col_q] = bus_in;
			col_q++;
		end
	end
	always @(negedge pins.rd_n) begin
		if (!pins.ce_n) begin
			out_q = page_q[col_q];
			col_q++;
		end
	end
	// released bus shows no stale byte
	assign dev_bus = (!pins.ce_n && !pins.rd_n) ? out_q : ~out_q;
endmodule

// ==== tb/nfhp_host_bench.sv ====
module nfhp_host_bench import nfhp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst, req_valid, req_ready, wp_level_n, rsp_valid, dev_busy;
	logic rb_pull, busy_req;
	logic [7:0] rsp_data, bus_in, bus_out, bus_oe, dev_bus;
	logic [15:0] read_count;
	nfhp_req_t req;
	nfhp_pins_t pins;
	logic [31:0] seed = 32'h62;
	logic [7:0] wd [8];
	logic [7:0] exp_q [$];
	logic [COL_BITS-1:0] c;
	logic [ROW_BITS-1:0] r;
	int miscompares = 0, comparisons = 0;
	assign bus_in = (bus_out & bus_oe) | (dev_bus & ~bus_oe);
	nfhp_host dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .wp_level_n(wp_level_n), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .dev_busy(dev_busy), .read_count(read_count), .pins(pins),
		.shared_bus_lines_in(bus_in), .shared_bus_lines_out(bus_out),
		.shared_bus_lines_oe(bus_oe), .ready_busy_in(~rb_pull));
	nfhp_dev_model dev (.pins(pins), .bus_in(bus_in), .dev_bus(dev_bus),
		.rb_pull(rb_pull), .busy_req(busy_req));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [16:0] got, input logic [16:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge core_clk);
		if (i == 40) begin
			miscompares++;
			end_of_test();
		end
	endtask
	// Waits for ready at the falling edge, so the next rising edge takes it
	task automatic send(input nfhp_op_t op, input logic [7:0] d);
		@(posedge core_clk);
		req <= '{op: op, data: d, col: c, row: r};
		req_valid <= 1'b1;
		@(negedge core_clk);
		wait_idle();
		@(posedge core_clk);
		req_valid <= 1'b0;
		@(negedge core_clk);
		wait_idle();
	endtask
	always @(posedge core_clk) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) check(17'(rsp_data), 17'h1ffff);
			else check(17'(rsp_data), 17'(exp_q.pop_front()));
		end
	end
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		wp_level_n = 1'b0;
		busy_req = 1'b0;
		c = '0;
		r = '0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			wd[k] = 8'(rnd());
			send(NFHP_OP_CMD, wd[k]);
			check(17'(dev.cmd_q), 17'(wd[k]));
		end
		check(17'(bus_oe), 17'h0);
		$display("command test done");
		c = 12'(rnd() % (PAGE_BYTES - 16));
		r = 17'(rnd());
		send(NFHP_OP_ADDR, 8'h00);
		check(17'(dev.col_q), 17'(c));
		check(dev.row_q, r);
		check(17'(dev.block_num), 17'(r[16:6]));
		check(17'(dev.page_num), 17'(r[5:0]));
		$display("address test done");
		for (int k = 0; k < 8; k++) begin
			wd[k] = 8'(rnd());
			send(NFHP_OP_WRITE, wd[k]);
		end
		check(17'(dev.col_q), 17'(c + 12'h8));
		$display("write test done");
		// A fresh address sequence opens with a command byte
		send(NFHP_OP_CMD, 8'h00);
		send(NFHP_OP_ADDR, 8'h00);
		for (int k = 0; k < 8; k++) begin
			exp_q.push_back(wd[k]);
			send(NFHP_OP_READ, 8'h00);
		end
		repeat (3) @(negedge core_clk);
		check(17'(read_count), 17'h8);
		check(17'(exp_q.size()), 17'h0);
		$display("read test done");
		busy_req <= 1'b1;
		repeat (2) @(negedge core_clk);
		check({15'h0, req_ready, dev_busy}, 17'h1);
		wd[0] = 8'(rnd());
		fork
			send(NFHP_OP_CMD, wd[0]);
			begin
				repeat (6) @(negedge core_clk);
				check(17'(pins.ce_n), 17'h1);
				check(17'(dev.cmd_q), 17'h0);
				busy_req <= 1'b0;
			end
		join
		check(17'(dev.cmd_q), 17'(wd[0]));
		@(posedge core_clk);
		wp_level_n <= 1'b1;
		repeat (2) @(negedge core_clk);
		check(17'(pins.wp_n), 17'h1);
		check({15'h0, req_ready, dev_busy}, 17'h2);
		$display("busy and protect test done");
		end_of_test();
	end
endmodule
